// ===== tmr8_pkg.sv
package tmr8_pkg;

  // ==========================================================================
  // Register indexes: byte address is four times the index.
  // Channel 0 sits one index below channel 1 for each per-channel register; the pair registers hold both channels.
  localparam logic [23:0] IDX_CTRL1 = 24'hffff69;
  localparam logic [23:0] IDX_STAT1 = 24'hffff6b;
  localparam logic [23:0] IDX_CORA1 = 24'hffff6d;
  localparam logic [23:0] IDX_CORB1 = 24'hffff6f;
  localparam logic [23:0] IDX_CNT1  = 24'hffff71;
  localparam logic [23:0] IDX_PCNT  = 24'hffff74;
  localparam logic [23:0] IDX_PCORA = 24'hffff75;
  localparam logic [23:0] IDX_PCORB = 24'hffff76;

  // ==========================================================================
  // Field positions.
  localparam int CTL_IEB = 7;
  localparam int CTL_IEA = 6;
  localparam int CTL_IEO = 5;
  localparam int CTL_CLR = 3;
  localparam int CTL_CKS = 0;
  localparam int STS_MFB = 7;
  localparam int STS_MFA = 6;
  localparam int STS_OVF = 5;
  localparam int STS_ADT = 4;
  localparam int STS_OSB = 2;
  localparam int STS_OSA = 0;

  // ==========================================================================
  // Reset values and the counter's top count.
  localparam logic [7:0] CNT_RST  = 8'h00;
  localparam logic [7:0] COR_RST  = 8'hff;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] CNT_TOP  = 8'hff;

  // ==========================================================================
  // Field encodings and prescaler rates.
  localparam logic [1:0] CLR_NONE = 2'h0;
  localparam logic [1:0] CLR_A    = 2'h1;
  localparam logic [1:0] CLR_B    = 2'h2;
  localparam logic [1:0] CLR_EXT  = 2'h3;
  localparam logic [2:0] CKS_STOP = 3'h0;
  localparam logic [2:0] CKS_D8   = 3'h1;
  localparam logic [2:0] CKS_D64  = 3'h2;
  localparam logic [2:0] CKS_SLOW = 3'h3;
  localparam logic [1:0] OS_KEEP  = 2'h0;
  localparam logic [1:0] OS_LOW   = 2'h1;
  localparam logic [1:0] OS_HIGH  = 2'h2;
  localparam logic [1:0] OS_TOGG  = 2'h3;
  localparam int         DIV_8    = 8;
  localparam int         DIV_64   = 64;
  localparam int         PRE_W    = 13;

endpackage

// ===== tmr8_timer.sv
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/10ps
module tmr8_timer
  import tmr8_pkg::*;
#(
  parameter int P_DIV_SLOW = 8192
)
(
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_nrst,
  // Wishbone slave
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [31:0] i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  // Timer pins, per channel
  input  wire logic [1:0]  i_ext_clr,
  output logic      [1:0]  o_tmr_out,
  output logic      [1:0]  o_conv_start,
  // Interrupt requests, per channel
  output logic      [1:0]  o_irq_ma,
  output logic      [1:0]  o_irq_mb,
  output logic      [1:0]  o_irq_ovf
);

  // ==========================================================================
  // Elaboration check
  if (P_DIV_SLOW < 128 || P_DIV_SLOW > 8192 ||
      (P_DIV_SLOW & (P_DIV_SLOW - 1)) != 0)
  begin : g_bad_div
    $error("P_DIV_SLOW must be a power of two from 128 to 8192");
  end

  localparam logic [PRE_W-1:0] M_D8   = PRE_W'(DIV_8 - 1);
  localparam logic [PRE_W-1:0] M_D64  = PRE_W'(DIV_64 - 1);
  localparam logic [PRE_W-1:0] M_SLOW = PRE_W'(P_DIV_SLOW - 1);

  function automatic logic hit(input logic [31:0] adr,
                               input logic [23:0] i1,
                               input int          g);
    logic [23:0] ix;
    ix  = i1 - 24'h1 + 24'(g);
    hit = adr == {6'h0, ix, 2'h0};
  endfunction

  function automatic logic os_apply(input logic [1:0] os,
                                    input logic       cur);
    case (os)
      OS_LOW:  os_apply = 1'b0;
      OS_HIGH: os_apply = 1'b1;
      OS_TOGG: os_apply = ~cur;
      default: os_apply = cur;
    endcase
  endfunction

  // ==========================================================================
  // Bus slave: one wait state, ack for one cycle, unmapped reads zero.
  logic             ack_reg;
  logic [PRE_W-1:0] pre_reg;
  logic [7:0]       cnt_reg  [2];
  logic [7:0]       cora_reg [2];
  logic [7:0]       corb_reg [2];
  logic [7:0]       ctl_reg  [2];
  logic [7:0]       sts_reg  [2];
  logic [7:0]       rd_ch    [2];
  logic [1:0]       w_cora;
  logic [1:0]       w_stat;
  logic [1:0]       tick;
  logic [1:0]       w_cnt;

  wire  req   = i_wb_cyc & i_wb_stb;
  wire  wfin  = req & i_wb_we & ack_reg;
  wire  rfin  = req & ~i_wb_we & ack_reg;
  wire  p_cnt = i_wb_adr == {6'h0, IDX_PCNT, 2'h0};
  wire  p_ca  = i_wb_adr == {6'h0, IDX_PCORA, 2'h0};
  wire  p_cb  = i_wb_adr == {6'h0, IDX_PCORB, 2'h0};

  wire [15:0] rd_pair =
    p_cnt ? {cnt_reg[0], cnt_reg[1]} :
    p_ca  ? {cora_reg[0], cora_reg[1]} :
    p_cb  ? {corb_reg[0], corb_reg[1]} : 16'h0;
  wire [31:0] rd_all = {16'h0, rd_pair} |
                       {24'h0, rd_ch[0] | rd_ch[1]};

  assign o_wb_ack = ack_reg;

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      ack_reg  <= 1'b0;
      o_wb_dat <= 32'h0;
    end
    else
    begin
      ack_reg <= req & ~ack_reg;
      if (req && !ack_reg)
        o_wb_dat <= rd_all;
    end
  end

  // ==========================================================================
  // Free-running prescaler shared by both channels.
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
      pre_reg <= '0;
    else
      pre_reg <= pre_reg + PRE_W'(1);
  end

  // ==========================================================================
  // Channels
  for (genvar g = 0; g < 2; g++)
  begin : g_ch
    localparam int PB = (1 - g) * 8;
    logic       ext_reg;
    logic       out_reg;
    logic       conv_reg;
    logic [2:0] arm_reg;

    wire [7:0] ctl = ctl_reg[g];
    wire [7:0] sts = sts_reg[g];
    wire [1:0] clr = ctl[CTL_CLR +: 2];
    wire [2:0] cks = ctl[CTL_CKS +: 3];
    wire       psel = i_wb_sel[1 - g];
    wire [7:0] pdat = i_wb_dat[PB +: 8];
    wire       bsel = i_wb_sel[0];
    wire [7:0] bdat = i_wb_dat[7:0];

    wire h_cnt = hit(i_wb_adr, IDX_CNT1, g);
    wire h_ca  = hit(i_wb_adr, IDX_CORA1, g);
    wire h_cb  = hit(i_wb_adr, IDX_CORB1, g);
    wire h_ctl = hit(i_wb_adr, IDX_CTRL1, g);
    wire h_sts = hit(i_wb_adr, IDX_STAT1, g);

    assign w_cnt[g]  = wfin & ((bsel & h_cnt) | (psel & p_cnt));
    assign w_cora[g] = wfin & ((bsel & h_ca) | (psel & p_ca));
    wire   w_corb    = wfin & ((bsel & h_cb) | (psel & p_cb));
    wire   w_ctl     = wfin & bsel & h_ctl;
    assign w_stat[g] = wfin & bsel & h_sts;
    wire [7:0] wd_cnt = h_cnt ? bdat : pdat;
    wire [7:0] wd_ca  = h_ca ? bdat : pdat;
    wire [7:0] wd_cb  = h_cb ? bdat : pdat;

    assign rd_ch[g] = h_cnt ? cnt_reg[g] :
                      h_ca  ? cora_reg[g] :
                      h_cb  ? corb_reg[g] :
                      h_ctl ? ctl : h_sts ? sts : 8'h0;

    assign tick[g] =
      (cks == CKS_D8)   ? (pre_reg & M_D8) == M_D8 :
      (cks == CKS_D64)  ? (pre_reg & M_D64) == M_D64 :
      (cks == CKS_SLOW) ? (pre_reg & M_SLOW) == M_SLOW :
      1'b0;

    wire m_a = tick[g] & (cnt_reg[g] == cora_reg[g]) & ~w_cora[g];
    wire m_b = tick[g] & (cnt_reg[g] == corb_reg[g]) & ~w_corb;
    wire ext_rise = i_ext_clr[g] & ~ext_reg;

    wire clr_now = (clr == CLR_A & m_a) | (clr == CLR_B & m_b) |
                   (clr == CLR_EXT & ext_rise);
    wire ovf_set = tick[g] & (cnt_reg[g] == CNT_TOP) & ~clr_now &
                   ~w_cnt[g];

    wire [7:0] cnt_next =
      w_cnt[g] ? wd_cnt :
      clr_now  ? CNT_RST :
      tick[g]  ? cnt_reg[g] + 8'h1 : cnt_reg[g];

    // clear only after read-as-1; set wins
    wire [2:0] set_v = {m_b, m_a, ovf_set};
    wire [2:0] flg   = sts[STS_OVF +: 3];
    wire [2:0] kill  = {3{w_stat[g]}} & arm_reg & ~bdat[STS_OVF +: 3];
    wire [2:0] flg_next = set_v | (flg & ~kill);
    wire [4:0] low_next = w_stat[g] ? bdat[4:0] : sts[4:0];

    // pin action, A after B so A wins a tie
    wire out_b = m_b ? os_apply(sts[STS_OSB +: 2], out_reg) : out_reg;
    wire out_next = m_a ? os_apply(sts[STS_OSA +: 2], out_b) : out_b;

    always_ff @(posedge i_ref_clk)
    begin
      if (!i_nrst)
      begin
        cnt_reg[g]  <= CNT_RST;
        cora_reg[g] <= COR_RST;
        corb_reg[g] <= COR_RST;
        ctl_reg[g]  <= CTRL_RST;
        sts_reg[g]  <= STAT_RST;
        arm_reg     <= 3'h0;
        ext_reg     <= 1'b0;
        out_reg     <= 1'b0;
        conv_reg    <= 1'b0;
      end
      else
      begin
        cnt_reg[g] <= cnt_next;
        if (w_cora[g])
          cora_reg[g] <= wd_ca;
        if (w_corb)
          corb_reg[g] <= wd_cb;
        if (w_ctl)
          ctl_reg[g] <= bdat;
        sts_reg[g] <= {flg_next, low_next};
        if (rfin && h_sts)
          arm_reg <= o_wb_dat[STS_OVF +: 3];
        else if (w_stat[g])
          arm_reg <= 3'h0;
        ext_reg  <= i_ext_clr[g];
        out_reg  <= out_next;
        conv_reg <= m_a & sts[STS_ADT];
      end
    end

    assign o_tmr_out[g]    = out_reg;
    assign o_conv_start[g] = conv_reg;
    assign o_irq_mb[g]  = sts[STS_MFB] & ctl[CTL_IEB];
    assign o_irq_ma[g]  = sts[STS_MFA] & ctl[CTL_IEA];
    assign o_irq_ovf[g] = sts[STS_OVF] & ctl[CTL_IEO];
  end

  // ==========================================================================
  // Checks on the bus ack and on channel 1, the one software pairs with channel 0.
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);

  wire [1:0] c1_clr = ctl_reg[1][CTL_CLR +: 2];
  wire [2:0] c1_cks = ctl_reg[1][CTL_CKS +: 3];
  wire [1:0] c1_osa = sts_reg[1][STS_OSA +: 2];
  wire [1:0] c1_osb = sts_reg[1][STS_OSB +: 2];

  a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held longer than one cycle");

  a_cnt_reset: assert property (
    !$past(i_nrst) |-> cnt_reg[1] == CNT_RST)
    else $error("counter not 00 after reset");

  a_cor_reset: assert property (
    !$past(i_nrst) |-> cora_reg[1] == COR_RST && corb_reg[1] == COR_RST)
    else $error("compare constant not ff after reset");

  a_ovf_wrap: assert property (
    tick[1] && cnt_reg[1] == CNT_TOP && c1_clr == CLR_NONE && !w_cnt[1]
    |=> sts_reg[1][STS_OVF] && cnt_reg[1] == CNT_RST)
    else $error("wrap did not set overflow");

  a_stop_hold: assert property (
    c1_cks == CKS_STOP && c1_clr == CLR_NONE && !w_cnt[1]
    |=> $stable(cnt_reg[1]))
    else $error("stopped counter moved");

  a_div8_rate: assert property (
    c1_cks == CKS_D8 && pre_reg[2:0] != 3'h7 && c1_clr == CLR_NONE &&
    !w_cnt[1] |=> $stable(cnt_reg[1]))
    else $error("counter advanced off the clock/8 edge");

  a_no_clear: assert property (
    c1_clr == CLR_NONE && cnt_reg[1] != 8'h0 && cnt_reg[1] != CNT_TOP &&
    !w_cnt[1] |=> cnt_reg[1] != 8'h0)
    else $error("counter cleared with clear field 00");

  a_match_a: assert property (
    tick[1] && cnt_reg[1] == cora_reg[1] && !w_cora[1]
    |=> sts_reg[1][STS_MFA])
    else $error("match A flag not set");

  a_cmp_suppress: assert property (
    w_cora[1] && !sts_reg[1][STS_MFA] |=> !sts_reg[1][STS_MFA])
    else $error("compare acted during constant write");

  a_flag_hold: assert property (
    sts_reg[1][STS_MFA] && !w_stat[1] |=> sts_reg[1][STS_MFA])
    else $error("match A flag lost without a clear");

  a_irq_ovf: assert property (
    $rose(sts_reg[1][STS_OVF]) && ctl_reg[1][CTL_IEO]
    |-> o_irq_ovf[1])
    else $error("overflow request missing");

  a_pin_keep: assert property (
    c1_osa == OS_KEEP && c1_osb == OS_KEEP |=> $stable(o_tmr_out[1]))
    else $error("pin changed with select pairs 00");

  c_overflow: cover property ($rose(sts_reg[1][STS_OVF]));
  c_match_a:  cover property ($rose(sts_reg[1][STS_MFA]));
  c_flag_clr: cover property ($fell(sts_reg[1][STS_MFA]));
  c_pin_togg: cover property ($changed(o_tmr_out[1]));

endmodule

// ===== tmr8_timer_test.sv
`timescale 1ns/10ps
module tmr8_timer_test;
  import tmr8_pkg::*;
  // ==========
  // Stimulus and observed signals.
  logic        i_ref_clk;
  logic        i_nrst;
  logic        i_wb_cyc;
  logic        i_wb_stb;
  logic        i_wb_we;
  logic [31:0] i_wb_adr;
  logic [3:0]  i_wb_sel;
  logic [31:0] i_wb_dat;
  logic [31:0] o_wb_dat;
  logic        o_wb_ack;
  logic [1:0]  i_ext_clr;
  logic [1:0]  o_tmr_out;
  logic [1:0]  o_conv_start;
  logic [1:0]  o_irq_ma;
  logic [1:0]  o_irq_mb;
  logic [1:0]  o_irq_ovf;
  logic [31:0] rd;
  time         t_req;
  int          fails;
  int          samples_checked;

  tmr8_timer #(.P_DIV_SLOW(128)) dut
  (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
    .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat),
    .o_wb_ack(o_wb_ack), .i_ext_clr(i_ext_clr), .o_tmr_out(o_tmr_out),
    .o_conv_start(o_conv_start), .o_irq_ma(o_irq_ma),
    .o_irq_mb(o_irq_mb), .o_irq_ovf(o_irq_ovf)
  );

  initial
  begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end

  // ==========
  // Bus and compare helpers.
  task automatic cmp(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // The request stands until ack is seen high at a rising edge; read data
  // is taken at that same edge, and only then is the request released.
  // A slave that never answers is left to the watchdog.
  task automatic bus(input logic we, input logic [23:0] idx,
                     input logic [3:0] sel, input logic [15:0] wd);
    @(posedge i_ref_clk);
    t_req = $time;
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we  <= we;
    i_wb_adr <= {6'h00, idx, 2'h0};
    i_wb_sel <= sel;
    i_wb_dat <= {16'h0000, wd};
    do
      @(posedge i_ref_clk);
    while (o_wb_ack !== 1'b1);
    rd = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    i_wb_we  <= 1'b0;
  endtask

  task automatic wr(input logic [23:0] idx, input logic [7:0] v);
    bus(1'b1, idx, 4'h1, {8'h00, v});
  endtask

  task automatic chk(input string what, input logic [23:0] idx,
                     input logic [7:0] exp);
    bus(1'b0, idx, 4'h1, 16'h0000);
    cmp(what, exp, rd[7:0]);
  endtask

  task automatic wait_hi(input bit on_b);
    int n = 0;
    do
    begin
      @(negedge i_ref_clk);
      n++;
    end
    while ((on_b ? o_irq_mb[1] : o_conv_start[1]) !== 1'b1 && n < 200);
  endtask

  task automatic ext_edge();
    @(posedge i_ref_clk);
    i_ext_clr <= 2'h2;
    repeat (4) @(posedge i_ref_clk);
    i_ext_clr <= 2'h0;
  endtask

  // ==========
  // Scenarios.
  task automatic t_reset();
    chk("count", IDX_CNT1, 8'h00);
    chk("const_a", IDX_CORA1, 8'hff);
    chk("const_b", IDX_CORB1, 8'hff);
    chk("control", IDX_CTRL1, 8'h00);
    chk("status", IDX_STAT1, 8'h00);
    cmp("outs", 8'h00, {o_tmr_out, o_irq_ma, o_irq_mb, o_irq_ovf});
    wr(24'h000010, 8'h5a);
    chk("unmapped", 24'h000010, 8'h00);
  endtask

  task automatic t_rw();
    wr(IDX_CNT1, 8'ha5);
    chk("count", IDX_CNT1, 8'ha5);
    bus(1'b1, IDX_PCNT, 4'h3, 16'h5a3c);
    chk("count0", IDX_CNT1 - 24'h1, 8'h5a);
    chk("count1", IDX_CNT1, 8'h3c);
    bus(1'b1, IDX_PCORA, 4'h3, 16'h1122);
    bus(1'b0, IDX_PCORA, 4'h3, 16'h0000);
    cmp("pair_a0", 8'h11, rd[15:8]);
    cmp("pair_a1", 8'h22, rd[7:0]);
  endtask

  // Two reads started exactly 64 clocks apart see eight clock/8 ticks between them.
  task automatic t_rate();
    logic [7:0] a;
    wr(IDX_CNT1, 8'h05);
    repeat (64) @(posedge i_ref_clk);
    chk("stopped", IDX_CNT1, 8'h05);
    wr(IDX_CTRL1, 8'h01);
    bus(1'b0, IDX_CNT1, 4'h1, 16'h0000);
    a = rd[7:0];
    while ($time < t_req + 6300) @(posedge i_ref_clk);
    bus(1'b0, IDX_CNT1, 4'h1, 16'h0000);
    cmp("ticks", 8'h08, rd[7:0] - a);
    wr(IDX_CTRL1, 8'h00);
  endtask

  task automatic t_ovf();
    wr(IDX_CNT1, 8'hfd);
    wr(IDX_CTRL1, 8'h21);
    repeat (48) @(negedge i_ref_clk);
    cmp("irq_ovf on", 8'h01, o_irq_ovf[1]);
    wr(IDX_CTRL1, 8'h00);
    @(negedge i_ref_clk);
    cmp("irq_ovf off", 8'h00, o_irq_ovf[1]);
    wr(IDX_STAT1, 8'h00);
    // Constant B still holds ff, so the wrap also sets match flag B.
    chk("ovf kept", IDX_STAT1, 8'ha0);
    wr(IDX_STAT1, 8'h00);
    chk("ovf clear", IDX_STAT1, 8'h00);
  endtask

  task automatic t_match_a();
    wr(IDX_CORA1, 8'h0f);
    wr(IDX_CNT1, 8'h0c);
    wr(IDX_STAT1, 8'h13);
    wr(IDX_CTRL1, 8'h49);
    wait_hi(1'b0);
    cmp("conv", 8'h01, o_conv_start[1]);
    cmp("pin a", 8'h01, o_tmr_out[1]);
    cmp("irq_ma", 8'h01, o_irq_ma[1]);
    chk("clear a", IDX_CNT1, 8'h00);
    wr(IDX_CTRL1, 8'h00);
    chk("flag a", IDX_STAT1, 8'h53);
  endtask

  task automatic t_match_b();
    wr(IDX_CORB1, 8'h12);
    wr(IDX_CNT1, 8'h0d);
    wr(IDX_STAT1, 8'h04);
    wr(IDX_CTRL1, 8'h91);
    wait_hi(1'b1);
    cmp("irq_mb", 8'h01, o_irq_mb[1]);
    cmp("pin b", 8'h00, o_tmr_out[1]);
    cmp("irq_ma off", 8'h00, o_irq_ma[1]);
    chk("clear b", IDX_CNT1, 8'h00);
    wr(IDX_CTRL1, 8'h00);
    chk("flag b", IDX_STAT1, 8'hc4);
  endtask

  task automatic t_ext();
    wr(IDX_CNT1, 8'h80);
    ext_edge();
    chk("no clear", IDX_CNT1, 8'h80);
    wr(IDX_CTRL1, 8'h18);
    ext_edge();
    chk("ext clear", IDX_CNT1, 8'h00);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // The whole run needs well under a millisecond of simulated time.
  initial
  begin
    #3000000;
    fails++;
    stop_test();
  end

  initial
  begin
    fails = 0;
    samples_checked = 0;
    i_nrst = 1'b0;
    i_wb_cyc = 1'b0;
    i_wb_stb = 1'b0;
    i_wb_we = 1'b0;
    i_wb_adr = 32'h0000_0000;
    i_wb_sel = 4'h0;
    i_wb_dat = 32'h0000_0000;
    i_ext_clr = 2'h0;
    repeat (20) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    t_reset();
    t_rw();
    t_rate();
    t_ovf();
    t_match_a();
    t_match_b();
    t_ext();
    stop_test();
  end
endmodule
